// ==== rtl/host_fifo_port.sv ====
/*
  flow control of a two-way host fifo port: an inbound fifo filled by the host and
  drained by the cpu, an outbound fifo filled by the cpu and read by the host, with
  watermarks, host requests, cpu status flags and interrupt lines.
  assumes host strobes arrive as pins from another clock domain and the cpu register
  port is synchronous to clk_sys, one access per cycle.
*/
// Function
// - inbound dma request follows write space when enabled
// - dma request routed to port_a_bit13_pin or pin two
// - read ready host interrupt when enabled
// - write space host interrupt when enabled
// - host interrupt pin chosen by shared setting
// - outbound watermark sets read ready level
// - inbound watermark sets write space level
// - rx ready set while data, cleared by read
// - rx half full set at sixteen bytes
// - tx empty flag set when fifo empty
// - tx half empty set at or below half
// - rx enable low flushes and blocks inbound
// - rx dma enable gates channel three requests
// - rx ready interrupt on port line one
// - rx half full interrupt on line one
// - bus error interrupt on port line four
// - tx interrupts on port line two
// - tx dma enable gates channel four requests
`default_nettype none
module host_fifo_port
  import host_fifo_pkg::*;
#(
  parameter int DEPTH = FIFO_BYTES / WORD_BYTES
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire host_fifo_pkg::reg_req_t cpuReq, // cpu register access
  output logic [31:0] cpuRdata, // cpu read data, one cycle after request
  input wire host_fifo_pkg::host_req_t hostReqPin, // host strobe pins
  output logic [15:0] hostRdata, // host read data
  input wire logic sharedRamAbort, // shared ram access aborted
  output host_fifo_pkg::port_out_t portOut // pins and internal request lines
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_WORDS = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_WORDS = CW'(FIFO_HALF_BYTES / WORD_BYTES);
  initial
  begin
    if (DEPTH * WORD_BYTES != FIFO_BYTES)
      $error("host_fifo_port depth must match a 32-byte fifo");
  end

  logic rstSync1;
  logic rstN;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync1 <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstN <= rstSync1;
    end
  end

  // host strobes: three stages, act when stages two and three agree
  host_req_t hostS1;
  host_req_t hostS2;
  host_req_t hostS3;
  logic hostSelSeen;
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      hostS1 <= '0;
      hostS2 <= '0;
      hostS3 <= '0;
      hostSelSeen <= 1'b0;
    end
    else
    begin
      hostS1 <= hostReqPin;
      hostS2 <= hostS1;
      hostS3 <= hostS2;
      if (hostS2.sel == hostS3.sel)
        hostSelSeen <= hostS3.sel;
    end
  end
  logic hostStrobe;
  assign hostStrobe = hostS2.sel && hostS3.sel && !hostSelSeen;

  function automatic logic levelMet(input logic [1:0] code, input logic [CW-1:0] n);
    unique case (watermark_t'(code))
      WM_ONE: levelMet = (n != '0);
      WM_HALF: levelMet = (n >= HALF_WORDS);
      WM_FULL: levelMet = (n == FULL_WORDS);
      WM_RESERVED: levelMet = (n == FULL_WORDS);
    endcase
  endfunction

  logic [31:0] generalControl;
  logic [31:0] hostIfControl;
  logic [31:0] pulsedInterrupt;
  logic [31:0] sharedRamBase;
  logic [31:0] sharedHostSettings;
  logic [15:0] hostMaskStatus;
  logic busError;

  logic cpuWr;
  logic cpuRd;
  assign cpuWr = cpuReq.sel && cpuReq.wr;
  assign cpuRd = cpuReq.sel && !cpuReq.wr;
  logic hostWr;
  logic hostRd;
  assign hostWr = hostStrobe && hostS3.wr;
  assign hostRd = hostStrobe && !hostS3.wr;

  // inbound: host writes, cpu reads
  logic rxEnable;
  logic rxInReady;
  logic rxOutValid;
  logic [31:0] rxOutData;
  logic [CW-1:0] rxCount;
  logic rxPop;
  logic rxPush;
  assign rxEnable = generalControl[RX_PATH_ENABLE_BIT];
  assign rxPush = rxEnable && hostWr && hostS3.addr == FIFO_DATA_HOST_ADDR;
  assign rxPop = cpuRd && cpuReq.addr == FIFO_DATA_WORD_ADDR;
  word_fifo #(.WIDTH(32), .DEPTH(DEPTH)) rxFifo (
    .clk(clk_sys),
    .rstN(rstN),
    .clear(!rxEnable),
    .inValid(rxPush),
    .inReady(rxInReady),
    .inData({16'h0000, hostS3.wdata}),
    .outValid(rxOutValid),
    .outReady(rxPop),
    .outData(rxOutData),
    .count(rxCount)
  );

  // outbound: cpu writes, host reads
  logic txInReady;
  logic txOutValid;
  logic [31:0] txOutData;
  logic [CW-1:0] txCount;
  logic txPush;
  logic txPop;
  assign txPush = cpuWr && cpuReq.addr == FIFO_DATA_WORD_ADDR;
  assign txPop = hostRd && hostS3.addr == FIFO_DATA_HOST_ADDR;
  word_fifo #(.WIDTH(32), .DEPTH(DEPTH)) txFifo (
    .clk(clk_sys),
    .rstN(rstN),
    .clear(1'b0),
    .inValid(txPush),
    .inReady(txInReady),
    .inData(cpuReq.wdata),
    .outValid(txOutValid),
    .outReady(txPop),
    .outData(txOutData),
    .count(txCount)
  );

  // host-visible levels from watermarks
  logic [CW-1:0] rxSpace;
  logic readDataReady;
  logic writeSpaceAvailable;
  assign rxSpace = FULL_WORDS - rxCount;
  assign readDataReady = levelMet(hostMaskStatus[OUTBOUND_WATERMARK_LSB +: 2], txCount);
  assign writeSpaceAvailable = rxEnable
    && levelMet(hostMaskStatus[INBOUND_WATERMARK_LSB +: 2], rxSpace);

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
      hostMaskStatus <= MASK_STATUS_RESET;
    else
    begin
      if (hostWr && hostS3.addr == MASK_STATUS_HOST_ADDR)
        hostMaskStatus[11:4] <= hostS3.wdata[11:4];
      hostMaskStatus[READ_DATA_READY_N_BIT] <= !readDataReady;
      hostMaskStatus[WRITE_SPACE_AVAILABLE_N_BIT] <= !writeSpaceAvailable;
    end
  end

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
      hostRdata <= '0;
    else if (hostRd && hostS3.addr == MASK_STATUS_HOST_ADDR)
      hostRdata <= hostMaskStatus;
    else if (txPop)
      hostRdata <= txOutData[15:0];
  end

  // cpu registers
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      generalControl <= WORD_RESET;
      hostIfControl <= WORD_RESET;
      pulsedInterrupt <= WORD_RESET;
      sharedRamBase <= WORD_RESET;
      sharedHostSettings <= WORD_RESET;
    end
    else if (cpuWr)
    begin
      unique case (cpuReq.addr)
        GENERAL_CONTROL_ADDR: generalControl <= cpuReq.wdata;
        HOST_IF_CONTROL_ADDR: hostIfControl <= cpuReq.wdata;
        PULSED_INTERRUPT_ADDR: pulsedInterrupt <= cpuReq.wdata;
        SHARED_RAM_BASE_ADDR: sharedRamBase <= cpuReq.wdata;
        SHARED_HOST_SETTINGS_ADDR: sharedHostSettings <= cpuReq.wdata;
        default:
        begin
        end
      endcase
    end
  end

  // bus error: set wins over write-one-to-clear
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
      busError <= 1'b0;
    else if (sharedRamAbort)
      busError <= 1'b1;
    else if (cpuWr && cpuReq.addr == GENERAL_STATUS_ADDR
             && cpuReq.wdata[SHARED_RAM_BUS_ERROR_BIT])
      busError <= 1'b0;
  end

  logic [31:0] statusWord;
  always_comb
  begin
    statusWord = '0;
    statusWord[RX_REGISTER_READY_BIT] = rxOutValid;
    statusWord[RX_HALF_FULL_BIT] = rxCount >= HALF_WORDS;
    statusWord[SHARED_RAM_BUS_ERROR_BIT] = busError;
    statusWord[TX_REGISTER_EMPTY_BIT] = txCount == '0;
    statusWord[TX_HALF_EMPTY_BIT] = txCount <= HALF_WORDS;
    statusWord[TX_FIFO_EMPTY_BIT] = txCount == '0;
  end

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
      cpuRdata <= '0;
    else if (cpuRd)
    begin
      unique case (cpuReq.addr)
        GENERAL_CONTROL_ADDR: cpuRdata <= generalControl;
        GENERAL_STATUS_ADDR: cpuRdata <= statusWord;
        FIFO_DATA_WORD_ADDR: cpuRdata <= rxOutData;
        HOST_IF_CONTROL_ADDR: cpuRdata <= hostIfControl;
        PULSED_INTERRUPT_ADDR: cpuRdata <= pulsedInterrupt;
        SHARED_RAM_BASE_ADDR: cpuRdata <= sharedRamBase;
        SHARED_HOST_SETTINGS_ADDR: cpuRdata <= sharedHostSettings;
        default: cpuRdata <= '0;
      endcase
    end
  end

  // request and interrupt outputs, all registered
  logic inboundDmaReq;
  logic hostIrq;
  logic dmaOnPa13;
  logic dmaOnPinTwo;
  logic irqOnPinTwo;
  assign inboundDmaReq = hostMaskStatus[INBOUND_DMA_REQ_ENABLE_BIT]
    && !hostMaskStatus[WRITE_SPACE_AVAILABLE_N_BIT];
  assign hostIrq = (hostMaskStatus[READ_READY_HOST_IRQ_ENABLE_BIT]
    && !hostMaskStatus[READ_DATA_READY_N_BIT])
    || (hostMaskStatus[WRITE_SPACE_HOST_IRQ_ENABLE_BIT]
    && !hostMaskStatus[WRITE_SPACE_AVAILABLE_N_BIT]);
  assign dmaOnPa13 = !hostIfControl[DMA_ROUTE_ENABLE_N_BIT]
    && !hostIfControl[DMA_ROUTE_SELECT_BIT];
  assign dmaOnPinTwo = !hostIfControl[DMA_ROUTE_ENABLE_N_BIT]
    && hostIfControl[DMA_ROUTE_SELECT_BIT];
  assign irqOnPinTwo = sharedHostSettings[HOST_IRQ_PIN_SELECT_BIT];

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
      portOut <= '{hostIrqOneN: 1'b1, hostIrqTwoN: 1'b1, default: 1'b0};
    else
    begin
      portOut.hostIrqOneN <= !(hostIrq && !irqOnPinTwo);
      portOut.hostIrqTwoN <= !((hostIrq && irqOnPinTwo)
        || (inboundDmaReq && dmaOnPinTwo));
      portOut.portABit13 <= inboundDmaReq && dmaOnPa13;
      portOut.rxPortIrq <= (generalControl[RX_READY_IRQ_ENABLE_BIT]
        && statusWord[RX_REGISTER_READY_BIT])
        || (generalControl[RX_HALF_FULL_IRQ_ENABLE_BIT]
        && statusWord[RX_HALF_FULL_BIT]);
      portOut.txPortIrq <= (generalControl[TX_READY_IRQ_ENABLE_BIT]
        && statusWord[TX_REGISTER_EMPTY_BIT])
        || (generalControl[TX_HALF_EMPTY_IRQ_ENABLE_BIT]
        && statusWord[TX_HALF_EMPTY_BIT]);
      portOut.busErrPortIrq <= generalControl[BUS_ERROR_IRQ_ENABLE_BIT] && busError;
      portOut.rxDmaReq <= generalControl[RX_DMA_ENABLE_BIT] && rxOutValid && !rxPop;
      portOut.txDmaReq <= generalControl[TX_DMA_ENABLE_BIT] && txInReady && !txPush;
    end
  end
endmodule // host_fifo_port
`default_nettype wire

// ==== inc/host_fifo_pkg.sv ====
/*
  shared constants and carrier types for the host fifo port flow control block.
  assumes a 32-bit internal register port with word addresses at the printed offsets.
*/
`default_nettype none
package host_fifo_pkg;
  localparam logic [31:0] GENERAL_CONTROL_ADDR = 32'hFFA00000;
  localparam logic [31:0] GENERAL_STATUS_ADDR = 32'hFFA00004;
  localparam logic [31:0] FIFO_DATA_WORD_ADDR = 32'hFFA00008;
  localparam logic [31:0] HOST_IF_CONTROL_ADDR = 32'hFFA00030;
  localparam logic [31:0] PULSED_INTERRUPT_ADDR = 32'hFFA00034;
  localparam logic [31:0] SHARED_RAM_BASE_ADDR = 32'hFFA00038;
  localparam logic [31:0] SHARED_HOST_SETTINGS_ADDR = 32'hFFA0003C;
  localparam logic [2:0] MASK_STATUS_HOST_ADDR = 3'h4;
  localparam logic [2:0] FIFO_DATA_HOST_ADDR = 3'h2;
  // general control fields
  localparam int RX_PATH_ENABLE_BIT = 31;
  localparam int RX_DMA_ENABLE_BIT = 30;
  localparam int RX_READY_IRQ_ENABLE_BIT = 27;
  localparam int RX_HALF_FULL_IRQ_ENABLE_BIT = 26;
  localparam int BUS_ERROR_IRQ_ENABLE_BIT = 24;
  localparam int TX_DMA_ENABLE_BIT = 22;
  localparam int TX_READY_IRQ_ENABLE_BIT = 19;
  localparam int TX_HALF_EMPTY_IRQ_ENABLE_BIT = 18;
  // general status fields
  localparam int RX_REGISTER_READY_BIT = 27;
  localparam int RX_HALF_FULL_BIT = 26;
  localparam int SHARED_RAM_BUS_ERROR_BIT = 24;
  localparam int TX_REGISTER_EMPTY_BIT = 19;
  localparam int TX_HALF_EMPTY_BIT = 18;
  localparam int TX_FIFO_EMPTY_BIT = 16;
  // host mask/status fields
  localparam int READ_DATA_READY_N_BIT = 13;
  localparam int WRITE_SPACE_AVAILABLE_N_BIT = 12;
  localparam int OUTBOUND_DMA_REQ_ENABLE_BIT = 11;
  localparam int INBOUND_DMA_REQ_ENABLE_BIT = 10;
  localparam int READ_READY_HOST_IRQ_ENABLE_BIT = 9;
  localparam int WRITE_SPACE_HOST_IRQ_ENABLE_BIT = 8;
  localparam int OUTBOUND_WATERMARK_LSB = 6;
  localparam int INBOUND_WATERMARK_LSB = 4;
  // host interface control and shared settings fields, then reset values and fifo sizes
  localparam int DMA_ROUTE_ENABLE_N_BIT = 1;
  localparam int DMA_ROUTE_SELECT_BIT = 0;
  localparam int HOST_IRQ_PIN_SELECT_BIT = 0;
  localparam logic [15:0] MASK_STATUS_RESET = 16'h3000;
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam int FIFO_BYTES = 32;
  localparam int FIFO_HALF_BYTES = 16;
  localparam int WORD_BYTES = 4;
  typedef enum logic [1:0] {WM_ONE, WM_HALF, WM_FULL, WM_RESERVED} watermark_t;
  typedef struct packed {
    logic sel;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic sel;
    logic wr;
    logic [2:0] addr;
    logic [15:0] wdata;
  } host_req_t;
  typedef struct packed {
    logic hostIrqOneN;
    logic hostIrqTwoN;
    logic portABit13;
    logic rxPortIrq;
    logic txPortIrq;
    logic busErrPortIrq;
    logic rxDmaReq;
    logic txDmaReq;
  } port_out_t;
endpackage
`default_nettype wire

// ==== rtl/word_fifo.sv ====
/*
  small flip-flop fifo with valid/ready on both sides and a fill count.
  assumes one clock; clear empties it synchronously.
*/
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk, // system clock
  input wire logic rstN, // async reset copy
  input wire logic clear, // synchronous flush
  input wire logic inValid, // source offers a word
  output logic inReady, // room for a word
  input wire logic [WIDTH-1:0] inData, // word in
  output logic outValid, // word available
  input wire logic outReady, // sink takes the word
  output logic [WIDTH-1:0] outData, // word out
  output logic [$clog2(DEPTH+1)-1:0] count // words held
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("word_fifo needs a power-of-two depth of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic push;
  logic pop;
  assign inReady = (count != CW'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr] <= inData;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else if (clear)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wrPtr <= wrPtr + AW'(1);
      if (pop)
        rdPtr <= rdPtr + AW'(1);
      if (push && !pop)
        count <= count + CW'(1);
      else if (pop && !push)
        count <= count - CW'(1);
    end
  end
endmodule // word_fifo
`default_nettype wire

// ==== testbench/host_fifo_port_sva.sv ====
/*
  checker for host_fifo_port: gating and routing of request and interrupt lines.
  assumes one clock domain and cpu writes visible on cpuReq.
*/
`default_nettype none
module host_fifo_port_sva #(
  parameter int DEPTH = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire host_fifo_pkg::reg_req_t cpuReq, // cpu register access
  input wire logic [31:0] cpuRdata, // cpu read data
  input wire host_fifo_pkg::host_req_t hostReqPin, // host strobe pins
  input wire logic [15:0] hostRdata, // host read data
  input wire logic sharedRamAbort, // shared ram abort
  input wire host_fifo_pkg::port_out_t portOut // pins and request lines
);
  timeunit 1ns;
  timeprecision 1ps;
  import host_fifo_pkg::*;
  logic [31:0] ctl;
  logic routeOff;
  logic pinTwo;
  // shadow of the cpu-written control fields
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      ctl <= '0;
      routeOff <= 1'b0;
      pinTwo <= 1'b0;
    end
    else if (cpuReq.sel && cpuReq.wr)
    begin
      if (cpuReq.addr == GENERAL_CONTROL_ADDR)
        ctl <= cpuReq.wdata;
      if (cpuReq.addr == HOST_IF_CONTROL_ADDR)
        routeOff <= cpuReq.wdata[DMA_ROUTE_ENABLE_N_BIT];
      if (cpuReq.addr == SHARED_HOST_SETTINGS_ADDR)
        pinTwo <= cpuReq.wdata[HOST_IRQ_PIN_SELECT_BIT];
    end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_reset_quiet;
    $rose(rst_n) |-> portOut == 8'hC0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output active at reset release");
  property p_rx_dma_gate;
    (!ctl[RX_DMA_ENABLE_BIT]) [*4] |-> !portOut.rxDmaReq;
  endproperty
  a_rx_dma_gate: assert property (p_rx_dma_gate)
    else $error("rx dma request while disabled");
  property p_tx_dma_gate;
    (!ctl[TX_DMA_ENABLE_BIT]) [*4] |-> !portOut.txDmaReq;
  endproperty
  a_tx_dma_gate: assert property (p_tx_dma_gate)
    else $error("tx dma request while disabled");
  property p_rx_off;
    (!ctl[RX_PATH_ENABLE_BIT]) [*4] |-> !portOut.rxPortIrq && !portOut.rxDmaReq;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("rx activity while rx path off");
  property p_rx_irq_gate;
    (!ctl[RX_READY_IRQ_ENABLE_BIT] && !ctl[RX_HALF_FULL_IRQ_ENABLE_BIT]) [*4]
      |-> !portOut.rxPortIrq;
  endproperty
  a_rx_irq_gate: assert property (p_rx_irq_gate)
    else $error("rx irq while masked");
  property p_tx_irq_gate;
    (!ctl[TX_READY_IRQ_ENABLE_BIT] && !ctl[TX_HALF_EMPTY_IRQ_ENABLE_BIT]) [*4]
      |-> !portOut.txPortIrq;
  endproperty
  a_tx_irq_gate: assert property (p_tx_irq_gate)
    else $error("tx irq while masked");
  property p_bus_err_raise;
    sharedRamAbort && ctl[BUS_ERROR_IRQ_ENABLE_BIT] |-> ##[1:4] portOut.busErrPortIrq;
  endproperty
  a_bus_err_raise: assert property (p_bus_err_raise)
    else $error("bus error irq missing");
  property p_pin_one_quiet;
    pinTwo [*4] |-> portOut.hostIrqOneN;
  endproperty
  a_pin_one_quiet: assert property (p_pin_one_quiet)
    else $error("host irq on pin one while pin two chosen");
  property p_route_off;
    routeOff [*4] |-> !portOut.portABit13;
  endproperty
  a_route_off: assert property (p_route_off)
    else $error("dma request on port pin while routing off");
endmodule // host_fifo_port_sva

bind host_fifo_port host_fifo_port_sva #(.DEPTH(DEPTH)) u_host_fifo_port_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .cpuReq(cpuReq), .cpuRdata(cpuRdata),
  .hostReqPin(hostReqPin), .hostRdata(hostRdata), .sharedRamAbort(sharedRamAbort),
  .portOut(portOut)
);
`default_nettype wire

// ==== testbench/host_model.sv ====
/*
  external host cpu on the host port pins: strobe cycles and flag-gated data moves.
  assumes the pins are synchronised to clk_sys inside the port.
*/
`default_nettype none
module host_model (
  input wire logic clk_sys, // system clock
  output var host_fifo_pkg::host_req_t hostReqPin, // host strobe pins
  input wire logic [15:0] hostRdata // host read data
);
  timeunit 1ns;
  timeprecision 1ps;
  import host_fifo_pkg::*;
  initial hostReqPin = '0;
  task automatic hacc(input logic wr, input logic [2:0] a, input logic [15:0] d,
      output logic [15:0] q);
    @(posedge clk_sys);
    #1;
    hostReqPin = '{sel: 1'b1, wr: wr, addr: a, wdata: d};
    repeat (6) @(posedge clk_sys);
    q = hostRdata;
    #1;
    // released lines show the inverse of the last value
    hostReqPin = '{sel: 1'b0, wr: ~wr, addr: ~a, wdata: ~d};
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic send(input logic [15:0] d);
    logic [15:0] s;
    hacc(1'b0, MASK_STATUS_HOST_ADDR, 16'h0000, s);
    if (!s[WRITE_SPACE_AVAILABLE_N_BIT])
      hacc(1'b1, FIFO_DATA_HOST_ADDR, d, s);
  endtask
  task automatic recv(output logic [15:0] q);
    logic [15:0] s;
    q = 16'hFFFF;
    hacc(1'b0, MASK_STATUS_HOST_ADDR, 16'h0000, s);
    if (!s[READ_DATA_READY_N_BIT])
      hacc(1'b0, FIFO_DATA_HOST_ADDR, 16'h0000, q);
  endtask
endmodule // host_model
`default_nettype wire

// ==== testbench/tb.sv ====
/*
  testbench for host_fifo_port: cpu register and host pin traffic with checks.
  assumes host_model and the checker are compiled before it.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import host_fifo_pkg::*;
  logic clk_sys;
  logic rst_n;
  reg_req_t cpuReq;
  logic [31:0] cpuRdata;
  host_req_t hostReqPin;
  logic [15:0] hostRdata;
  logic sharedRamAbort;
  port_out_t po;
  int badCount = 0;
  int checks = 0;
  int cycles = 0;
  int i;
  logic [31:0] r;
  logic [15:0] q;
  host_fifo_port u_host_fifo_port (.clk_sys(clk_sys), .rst_n(rst_n), .cpuReq(cpuReq),
    .cpuRdata(cpuRdata), .hostReqPin(hostReqPin), .hostRdata(hostRdata),
    .sharedRamAbort(sharedRamAbort), .portOut(po));
  host_model u_host_model (.clk_sys(clk_sys), .hostReqPin(hostReqPin),
    .hostRdata(hostRdata));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop();
    $display("checks %0d badCount %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      badCount++;
      report_and_stop();
    end
  end
  task automatic ck(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ckb(input string what, input logic seen, input logic exp);
    ck(what, {31'h0, seen}, {31'h0, exp});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d);
    wt(1);
    cpuReq = '{sel: 1'b1, wr: wr, addr: a, wdata: d};
    wt(1);
    cpuReq.sel = 1'b0;
    wt(1);
    r = cpuRdata;
  endtask
  task automatic sb(input int b, input logic e);
    acc(1'b0, GENERAL_STATUS_ADDR, 32'h00000000);
    ckb("status bit", r[b], e);
  endtask
  task automatic hm(input logic [15:0] m);
    u_host_model.hacc(1'b1, MASK_STATUS_HOST_ADDR, m, q);
  endtask
  task automatic hb(input int b, input logic e);
    u_host_model.hacc(1'b0, MASK_STATUS_HOST_ADDR, 16'h0000, q);
    ckb("host status bit", q[b], e);
  endtask
  initial
  begin
    cpuReq = '0;
    sharedRamAbort = 1'b0;
    rst_n = 1'b0;
    wt(2);
    rst_n = 1'b1;
    wt(3);
    acc(1'b0, GENERAL_CONTROL_ADDR, 32'h00000000);
    ck("control", r, 32'h00000000);
    acc(1'b0, GENERAL_STATUS_ADDR, 32'h00000000);
    ck("status", r, 32'h000D0000);
    acc(1'b0, 32'hFFA00010, 32'h00000000);
    ck("unmapped", r, 32'h00000000);
    acc(1'b1, GENERAL_CONTROL_ADDR, 32'h00080000);
    wt(4);
    ckb("tx irq", po.txPortIrq, 1'b1);
    for (i = 1; i <= 5; i++)
    begin
      acc(1'b1, FIFO_DATA_WORD_ADDR, 32'hA5A50000 + 32'(i));
      sb(TX_REGISTER_EMPTY_BIT, 1'b0);
      sb(TX_HALF_EMPTY_BIT, i <= 4);
    end
    ckb("tx irq", po.txPortIrq, 1'b0);
    acc(1'b1, GENERAL_CONTROL_ADDR, 32'h00040000);
    for (i = 0; i < 4; i++)
    begin
      hm(16'h0200 | 16'(i << OUTBOUND_WATERMARK_LSB));
      hb(READ_DATA_READY_N_BIT, i >= 2);
      ckb("irq one", po.hostIrqOneN, i >= 2);
    end
    acc(1'b1, SHARED_HOST_SETTINGS_ADDR, 32'h00000001);
    hm(16'h0200);
    ckb("irq two", po.hostIrqTwoN, 1'b0);
    acc(1'b1, SHARED_HOST_SETTINGS_ADDR, 32'h00000000);
    for (i = 6; i <= 9; i++)
      acc(1'b1, FIFO_DATA_WORD_ADDR, 32'hA5A50000 + 32'(i));
    hm(16'h00C0);
    hb(READ_DATA_READY_N_BIT, 1'b0);
    hm(16'h0000);
    for (i = 1; i <= 8; i++)
    begin
      u_host_model.recv(q);
      ck("host data", {16'h0000, q}, 32'(i));
    end
    sb(TX_FIFO_EMPTY_BIT, 1'b1);
    ckb("tx half irq", po.txPortIrq, 1'b1);
    acc(1'b1, GENERAL_CONTROL_ADDR, 32'h00400000);
    wt(4);
    ckb("tx dma", po.txDmaReq, 1'b1);
    u_host_model.hacc(1'b1, FIFO_DATA_HOST_ADDR, 16'h00EE, q);
    acc(1'b1, GENERAL_CONTROL_ADDR, 32'hC8000000);
    wt(4);
    sb(RX_REGISTER_READY_BIT, 1'b0);
    hm(16'h0500);
    for (i = 1; i <= 4; i++)
      u_host_model.send(16'h0010 + 16'(i));
    sb(RX_REGISTER_READY_BIT, 1'b1);
    sb(RX_HALF_FULL_BIT, 1'b1);
    ckb("rx irq", po.rxPortIrq, 1'b1);
    ckb("rx dma", po.rxDmaReq, 1'b1);
    for (i = 0; i < 4; i++)
    begin
      hm(16'h0500 | 16'(i << INBOUND_WATERMARK_LSB));
      hb(WRITE_SPACE_AVAILABLE_N_BIT, i >= 2);
      ckb("port_a_bit13_pin dma", po.portABit13, i < 2);
      ckb("irq one", po.hostIrqOneN, i >= 2);
    end
    hm(16'h0400);
    acc(1'b1, HOST_IF_CONTROL_ADDR, 32'h00000001);
    wt(4);
    ckb("pin two dma", po.hostIrqTwoN, 1'b0);
    ckb("port_a_bit13_pin dma", po.portABit13, 1'b0);
    acc(1'b1, HOST_IF_CONTROL_ADDR, 32'h00000002);
    wt(4);
    ckb("pin two dma", po.hostIrqTwoN, 1'b1);
    acc(1'b1, HOST_IF_CONTROL_ADDR, 32'h00000000);
    hm(16'h0000);
    ckb("port_a_bit13_pin masked", po.portABit13, 1'b0);
    acc(1'b1, GENERAL_CONTROL_ADDR, 32'h88000000);
    wt(4);
    ckb("rx dma", po.rxDmaReq, 1'b0);
    for (i = 1; i <= 4; i++)
    begin
      acc(1'b0, FIFO_DATA_WORD_ADDR, 32'h00000000);
      ck("rx data", r, 32'h00000010 + 32'(i));
      sb(RX_HALF_FULL_BIT, 1'b0);
    end
    sb(RX_REGISTER_READY_BIT, 1'b0);
    acc(1'b1, GENERAL_CONTROL_ADDR, 32'h84000000);
    for (i = 1; i <= 4; i++)
    begin
      u_host_model.send(16'h0020);
      ckb("rx half irq", po.rxPortIrq, i == 4);
    end
    acc(1'b1, GENERAL_CONTROL_ADDR, 32'h00000000);
    acc(1'b1, GENERAL_CONTROL_ADDR, 32'h84000000);
    wt(4);
    sb(RX_REGISTER_READY_BIT, 1'b0);
    ckb("rx half irq", po.rxPortIrq, 1'b0);
    acc(1'b1, GENERAL_CONTROL_ADDR, 32'h01000000);
    sharedRamAbort = 1'b1;
    wt(1);
    sharedRamAbort = 1'b0;
    wt(4);
    ckb("bus error irq", po.busErrPortIrq, 1'b1);
    sb(SHARED_RAM_BUS_ERROR_BIT, 1'b1);
    rst_n = 1'b0;
    wt(1);
    ck("outputs", {24'h000000, po}, 32'h000000C0);
    rst_n = 1'b1;
    wt(3);
    acc(1'b0, GENERAL_CONTROL_ADDR, 32'h00000000);
    ck("control", r, 32'h00000000);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
